// ==== design/vif_frontend.sv ====
// Module: video input front end with register slave, loopback mux and clocking
// Functional notes
// - Sample bus on clock rise when strobe high
// - Strobe low means nothing sampled
// - Sampling path rated to 81 MHz
// - Low eight bits carry YUV or raw
// - Bits 8/9 extend data, flag message start/end
// - Output clock is processor clock divided by an integer
// - Loopback bit selects video output unit signals
// - Loopback only steers the input multiplexer
// - Power-down unless sleepless; sleepless keeps running, wakes
// - Reset by pin or control write 0x00080000
// - Reset clears control, status, clock registers
// - Internal-select zero: async input, divider ignored
// - Loopback plus external uses output unit clock
// - Internal-select one: drive clock, sample its rises
// - Generated rate equals processor clock over divider
// - Reset leaves external clocking mode
`timescale 1ns/1ps
module vif_frontend (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic video_sample_clock_pin_i,
  output logic video_sample_clock_pin_o,
  output logic video_sample_clock_pin_oe,
  input wire logic input_valid_strobe,
  input wire logic [9:0] video_input_bus,
  input wire logic vout_clk,
  input wire logic vout_valid,
  input wire logic [9:0] vout_data,
  input wire logic global_power_down,
  output logic unit_powered_down,
  output logic wake_request,
  input wire logic irq_event,
  output logic [9:0] sample_data,
  output logic sample_valid,
  output logic [3:0] capture_mode,
  output logic capture_enable
);
  // ********************
  // Registers
  // ********************
  // Software-visible state; soft reset clears all of it
  logic [31:0] input_control_register_r;
  logic [31:0] input_clock_config_register_r;
  // Capture path state
  logic [15:0] sample_count_r;
  logic overrun_r;
  logic [9:0] sample_data_r;
  logic sample_valid_r;
  logic [9:0] sample_hold_r;
  logic hold_valid_r;
  // Write channel state
  logic aw_got_r;
  logic w_got_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  // Response and read channel state
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Decode of a byte address to a register hit, used for reads and writes
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == vif_pkg::ADDR_CTL) || (a == vif_pkg::ADDR_STATUS) ||
                  (a == vif_pkg::ADDR_CLOCK) || (a == vif_pkg::ADDR_SAMPLE);
  endfunction

  // Byte-lane merge for writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ********************
  // Control decode
  // ********************
  // Fields pulled from the control and clock registers
  wire loopback_select_bit = input_control_register_r[vif_pkg::CTL_LOOPBACK_BIT];
  wire sleepless = input_control_register_r[vif_pkg::CTL_SLEEPLESS_BIT];
  wire internal_clock_select = input_clock_config_register_r[vif_pkg::CLK_INTERNAL_BIT];
  wire [vif_pkg::DIV_W-1:0] divider_field =
    input_clock_config_register_r[vif_pkg::CLK_DIV_LSB +: vif_pkg::DIV_W];
  // Sleepless keeps the unit alive through global power-down
  wire powered_down = global_power_down && !sleepless;

  // ********************
  // Write channel
  // ********************
  // Handshakes and write decode
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_got_r && w_got_r && !bvalid_r;
  wire wr_hit = addr_mapped(aw_addr_r);
  wire [31:0] ctl_merged = lane_merge(input_control_register_r, w_data_r, w_strb_r);
  // Register selects for the two writable words
  wire wr_ctl = wr_go && (aw_addr_r == vif_pkg::ADDR_CTL);
  wire wr_clk = wr_go && (aw_addr_r == vif_pkg::ADDR_CLOCK);
  // Soft reset is a whole-word match; it also clears the capture path
  wire soft_reset = wr_ctl && (ctl_merged == vif_pkg::CTL_SOFT_RESET_WORD);
  wire unit_reset = !aresetn || soft_reset;
  // Ready drops while a write is held or its response stands
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;

  // Address and data may arrive in either order; latch each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else begin
      if (aw_fire) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr & ~12'h003;
      end else if (wr_go) begin
        aw_got_r <= 1'b0;
      end
      if (w_fire) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // Write response, one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= vif_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? vif_pkg::RESP_OKAY : vif_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  // Response outputs come straight from flops
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ********************
  // Control and clock registers
  // ********************
  // Soft reset clears both registers; loopback must be rewritten after
  always_ff @(posedge aclk) begin
    if (unit_reset) begin
      input_control_register_r <= vif_pkg::REG_ZERO;
      input_clock_config_register_r <= vif_pkg::REG_ZERO;
    end else begin
      if (wr_ctl) begin
        input_control_register_r <= ctl_merged;
      end
      if (wr_clk) begin
        input_clock_config_register_r <=
          lane_merge(input_clock_config_register_r, w_data_r, w_strb_r);
      end
    end
  end

  // ********************
  // Input multiplexer
  // ********************
  // Loopback swaps only the source; every mode stays usable
  wire [9:0] mux_data = loopback_select_bit ? vout_data : video_input_bus;
  wire mux_valid = loopback_select_bit ? vout_valid : input_valid_strobe;
  wire ext_clk = loopback_select_bit ? vout_clk : video_sample_clock_pin_i;

  // ********************
  // Clock generation and sampling edge
  // ********************
  logic gen_clk;
  logic gen_rise;
  logic ext_rise;
  // Divider held in reset outside internal mode and in power-down, so restart is clean
  vif_clkdiv u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(internal_clock_select && !powered_down),
    .divider(divider_field),
    .clk_out(gen_clk),
    .rise_pulse(gen_rise)
  );
  // Only the clock level crosses through the synchroniser
  vif_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(ext_clk),
    .rise(ext_rise)
  );
  // Divider ignored in external mode; pin only driven in internal mode
  wire sample_edge = internal_clock_select ? gen_rise : ext_rise;
  assign video_sample_clock_pin_o = gen_clk;
  assign video_sample_clock_pin_oe = internal_clock_select;

  // Data is held each aclk so the value present before the synchronised
  // edge is the one taken; the 10 MHz model clock bounds the real 81 MHz rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_hold_r <= '0;
      hold_valid_r <= 1'b0;
    end else begin
      sample_hold_r <= mux_data;
      hold_valid_r <= mux_valid;
    end
  end
  // Divider edges are aclk-aligned, so internal mode takes the live pins
  wire held_valid = internal_clock_select ? mux_valid : hold_valid_r;
  wire [9:0] take_word = internal_clock_select ? mux_data : sample_hold_r;
  wire take = sample_edge && held_valid && !powered_down;

  // ********************
  // Sample capture
  // ********************
  // Full ten bits kept; bits 8/9 are message flags in message mode
  always_ff @(posedge aclk) begin
    if (unit_reset) begin
      sample_data_r <= '0;
      sample_valid_r <= 1'b0;
      sample_count_r <= '0;
      overrun_r <= 1'b0;
    end else begin
      sample_valid_r <= take;
      if (take) begin
        sample_data_r <= take_word;
        sample_count_r <= sample_count_r + 16'h0001;
        overrun_r <= overrun_r || sample_valid_r;
      end
    end
  end
  // Sample outputs from flops, mode and enable from control, power and wake decoded live
  assign sample_data = sample_data_r;
  assign sample_valid = sample_valid_r;
  assign capture_mode = input_control_register_r[vif_pkg::CTL_MODE_LSB +: 4];
  assign capture_enable = input_control_register_r[vif_pkg::CTL_CAPTURE_EN_BIT];
  assign unit_powered_down = powered_down;
  assign wake_request = global_power_down && sleepless && irq_event;

  // ********************
  // Read channel
  // ********************
  // Status assembled live from counters and power state
  wire [31:0] status_word = (32'(sample_count_r) << vif_pkg::ST_COUNT_LSB) |
    (32'(overrun_r) << vif_pkg::ST_OVERRUN_BIT) |
    (32'(powered_down) << vif_pkg::ST_POWERED_DOWN_BIT);
  // Byte address trimmed to a word
  wire [11:0] ar_addr = s_axi_araddr & ~12'h003;
  // Unmapped addresses read as zero with an error response
  wire [31:0] rd_word =
    (ar_addr == vif_pkg::ADDR_CTL) ? input_control_register_r :
    (ar_addr == vif_pkg::ADDR_STATUS) ? status_word :
    (ar_addr == vif_pkg::ADDR_CLOCK) ? input_clock_config_register_r :
    (ar_addr == vif_pkg::ADDR_SAMPLE) ? 32'(sample_data_r) : vif_pkg::REG_ZERO;
  // One read outstanding; a new address waits while data stands
  assign s_axi_arready = !rvalid_r;
  // Read answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= vif_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= addr_mapped(ar_addr) ? vif_pkg::RESP_OKAY : vif_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule // vif_frontend

// ==== design/vif_pkg.sv ====
// Package: register map, field layout and shared types of the video input front end
package vif_pkg;
  // ********************
  // Register map
  // ********************
  localparam logic [11:0] ADDR_CTL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CLOCK = 12'h008;
  localparam logic [11:0] ADDR_SAMPLE = 12'h00c;
  localparam logic [31:0] CTL_SOFT_RESET_WORD = 32'h00080000;
  localparam logic [31:0] REG_ZERO = 32'h00000000;
  // Control bit positions
  localparam int CTL_CAPTURE_EN_BIT = 0;
  localparam int CTL_LOOPBACK_BIT = 1;
  localparam int CTL_SLEEPLESS_BIT = 2;
  localparam int CTL_MODE_LSB = 4;
  // Clock config bit positions
  localparam int CLK_INTERNAL_BIT = 0;
  localparam int CLK_DIV_LSB = 8;
  localparam int DIV_W = 8;
  // Status bit positions
  localparam int ST_POWERED_DOWN_BIT = 0;
  localparam int ST_OVERRUN_BIT = 1;
  localparam int ST_COUNT_LSB = 16;
  // Bus widths and timing
  localparam int DATA_W = 10;
  localparam int MSG_START_BIT = 8;
  localparam int MSG_END_BIT = 9;
  localparam int MAX_SAMPLE_MHZ = 81;
  localparam int SYS_CLK_MHZ = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
  // Capture modes carried in control
  typedef enum logic [3:0] {
    VIF_MODE_FULLRES = 4'h0,
    VIF_MODE_HALFRES = 4'h1,
    VIF_MODE_RAW8 = 4'h2,
    VIF_MODE_RAW10S = 4'h3,
    VIF_MODE_RAW10U = 4'h4,
    VIF_MODE_MESSAGE = 4'h5
  } vif_mode_t;
  // One sampled bus word
  typedef struct packed {
    logic msg_end;
    logic msg_start;
    logic [7:0] pixel;
  } vif_sample_t;
  // Source-side pins as a group
  typedef struct packed {
    logic clk;
    logic valid;
    logic [DATA_W-1:0] data;
  } vif_pins_t;
endpackage

// ==== design/vif_clkdiv.sv ====
// Module: programmable divider producing the internal video sample clock
`timescale 1ns/1ps
module vif_clkdiv (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic [vif_pkg::DIV_W-1:0] divider,
  output logic clk_out,
  output logic rise_pulse
);
  logic [vif_pkg::DIV_W-1:0] cnt_r;
  logic [vif_pkg::DIV_W-1:0] div_r;
  logic clk_r;
  wire [vif_pkg::DIV_W-1:0] eff_div = (divider == '0) ? vif_pkg::DIV_ONE : divider;
  wire [vif_pkg::DIV_W-1:0] half = div_r >> 1;
  wire period_end = (cnt_r >= div_r - vif_pkg::DIV_ONE);
  // ********************
  // Divider counter
  // ********************
  // New divider only loads at a period end, so no runt pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      cnt_r <= '0;
      div_r <= vif_pkg::DIV_ONE;
      clk_r <= 1'b0;
    end else if (period_end) begin
      cnt_r <= '0;
      div_r <= eff_div;
      clk_r <= (eff_div != vif_pkg::DIV_ONE);
    end else begin
      cnt_r <= cnt_r + vif_pkg::DIV_ONE;
      clk_r <= (cnt_r + vif_pkg::DIV_ONE) < half || half == '0;
    end
  end
  // Sample point once per generated period
  assign rise_pulse = enable && period_end;
  assign clk_out = clk_r;
endmodule // vif_clkdiv

// ==== design/vif_sync.sv ====
// Module: two-flop level synchroniser with rising edge detect
`timescale 1ns/1ps
module vif_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic rise
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  // ********************
  // Synchroniser
  // ********************
  // Only sync_r reads the first flop; rise compares sync_r with prev_r
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign rise = sync_r && !prev_r;
endmodule // vif_sync

// ==== verification/vif_frontend_chk.sv ====
// Checker: port-level properties of the video input front end
`timescale 1ns/1ps
module vif_frontend_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic video_sample_clock_pin_oe,
  input wire logic input_valid_strobe,
  input wire logic vout_valid,
  input wire logic global_power_down,
  input wire logic unit_powered_down,
  input wire logic wake_request,
  input wire logic irq_event,
  input wire logic sample_valid,
  input wire logic capture_enable
);
  // ********************
  // Helper logic
  // ********************
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  // Saturating run of strobe-free cycles; covers the synchroniser delay
  assign quiet_nxt = (input_valid_strobe || vout_valid) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quiet_r <= 4'h0;
    end else begin
      quiet_r <= quiet_nxt;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ********************
  // Properties
  // ********************
  a_quiet_no_sample: assert property (quiet_r >= 4'h6 |-> !sample_valid)
    else $error("sample produced without strobe");
  a_pd_needs_gpd: assert property (
    !global_power_down |-> !unit_powered_down && !wake_request)
    else $error("power-down or wake without global power-down");
  a_pd_no_sample: assert property (unit_powered_down [*2] |-> !sample_valid)
    else $error("sample while powered down");
  a_wake_cause: assert property (
    wake_request |-> irq_event && global_power_down && !unit_powered_down)
    else $error("wake without sleepless event");
  a_wake_when: assert property (
    global_power_down && !unit_powered_down && irq_event |-> wake_request)
    else $error("sleepless event did not wake");
  a_soft_reset: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == vif_pkg::ADDR_CTL && s_axi_wdata == vif_pkg::CTL_SOFT_RESET_WORD
    |-> ##[1:2] (!capture_enable && !video_sample_clock_pin_oe))
    else $error("soft reset left state set");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  // Main scenarios reached
  c_internal_sample: cover property (sample_valid && video_sample_clock_pin_oe);
  c_wake: cover property (wake_request);
  c_pd_leave: cover property (unit_powered_down ##1 !unit_powered_down);
endmodule // vif_frontend_chk

bind vif_frontend vif_frontend_chk i_vif_frontend_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .video_sample_clock_pin_oe,
  .input_valid_strobe, .vout_valid, .global_power_down, .unit_powered_down,
  .wake_request, .irq_event, .sample_valid, .capture_enable
);

// ==== verification/vif_src_model.sv ====
// Partner model: video source driving clock, strobe and data pins
`timescale 1ns/1ps
module vif_src_model #(
  parameter int HALF = 5
) (
  input wire logic aclk,
  input wire logic run,
  input wire logic ven,
  input wire logic clk_in,
  input wire logic [9:0] base,
  output logic own_clk,
  output logic valid,
  output logic [9:0] data
);
  int hc = 0;
  logic prev = 1'b0;
  logic [9:0] cnt = 10'h000;
  initial own_clk = 1'b0;
  initial valid = 1'b0;
  initial data = 10'h000;
  // Own clock; finishes its high phase, then stands still low
  always @(posedge aclk) begin
    if (run || own_clk) begin
      hc <= (hc == HALF - 1) ? 0 : hc + 1;
      if (hc == HALF - 1) begin
        own_clk <= !own_clk;
      end
    end
  end
  // New word after each fall, so it is steady across the next rise
  always @(posedge aclk) begin
    prev <= clk_in;
    if (prev && !clk_in) begin
      cnt <= cnt + 10'h001;
      valid <= ven && cnt[1:0] != 2'h3;
      data <= (ven && cnt[1:0] != 2'h3) ? base + cnt : ~data;
    end
  end
endmodule // vif_src_model

// ==== verification/tb.sv ====
// Testbench: video input front end against a source model and a queue model
`timescale 1ns/1ps
module tb;
  // ********************
  // Signals and instances
  // ********************
  logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, ven = 1'b0, lb = 1'b0, pdm = 1'b0, pv = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, global_power_down = 0, irq_event = 0;
  logic [9:0] base = 10'h000;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic video_sample_clock_pin_o, video_sample_clock_pin_oe, own, vld;
  wire logic unit_powered_down, wake_request, sample_valid, capture_enable;
  wire logic [3:0] capture_mode;
  wire logic [9:0] sample_data, dat;
  int fails = 0, checked = 0, cyc = 0, dv = 0;
  logic [9:0] q[$];
  // Pin levels; the unselected source shows no clock and inverted data
  wire logic pin = video_sample_clock_pin_oe ? video_sample_clock_pin_o : own;
  wire logic video_sample_clock_pin_i = lb ? 1'b0 : pin;
  wire logic vout_clk = lb ? pin : 1'b0;
  wire logic input_valid_strobe = lb ? 1'b0 : vld;
  wire logic vout_valid = lb ? vld : 1'b0;
  wire logic [9:0] video_input_bus = lb ? ~dat : dat;
  wire logic [9:0] vout_data = lb ? dat : ~dat;
  always #50 aclk = ~aclk;
  vif_frontend i_vif_frontend (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .video_sample_clock_pin_i,
    .video_sample_clock_pin_o, .video_sample_clock_pin_oe, .input_valid_strobe,
    .video_input_bus, .vout_clk, .vout_valid, .vout_data, .global_power_down,
    .unit_powered_down, .wake_request, .irq_event, .sample_data, .sample_valid,
    .capture_mode, .capture_enable
  );
  vif_src_model i_vif_src_model (.aclk, .run, .ven, .clk_in(pin), .base,
    .own_clk(own), .valid(vld), .data(dat));
  // ********************
  // Tasks
  // ********************
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] er = vif_pkg::RESP_OKAY);
    logic aw = 1'b1;
    logic w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp({30'h0, s_axi_bresp}, {30'h0, er});
    // One idle edge so a following call never re-drives bready in this step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e = vif_pkg::REG_ZERO,
      input logic [1:0] er = vif_pkg::RESP_OKAY);
    logic ar = 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (ar && s_axi_arready === 1'b1) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp(s_axi_rdata, e);
    cmp({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  // Counting words from a random base for n cycles, then drain the pipeline
  task automatic stream(input int n);
    base <= 10'($urandom);
    ven <= 1'b1;
    repeat (n) @(posedge aclk);
    ven <= 1'b0;
    repeat (60) @(posedge aclk);
  endtask
  task automatic per(input int e);
    time t;
    @(posedge video_sample_clock_pin_o);
    t = $time;
    @(posedge video_sample_clock_pin_o);
    cmp(32'(($time - t) / 100), 32'(e));
    @(posedge aclk);
  endtask
  task automatic fin(input string s);
    cmp(32'(q.size()), 32'h0);
    $display("test %s done", s);
  endtask
  // Reference model: each strobed rise of the live clock yields one word unless pdm is set; hang guard
  always @(posedge aclk) begin
    cyc = cyc + 1;
    pv <= pin;
    if (!pv && pin && vld && !pdm) begin
      q.push_back(dat);
    end
    if (sample_valid === 1'b1) begin
      cmp({22'h0, sample_data},
          q.size() > 0 ? {22'h0, q.pop_front()} : 32'hffffffff);
    end
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  // ********************
  // Main sequence
  // ********************
  initial begin
    void'($urandom(32'h2bae));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(vif_pkg::ADDR_CTL);
    rd(vif_pkg::ADDR_CLOCK);
    cmp({31'h0, video_sample_clock_pin_oe}, 32'h0);
    wr(vif_pkg::ADDR_STATUS, 32'hffffffff);
    rd(vif_pkg::ADDR_STATUS);
    wr(12'h010, 32'h1, vif_pkg::RESP_SLVERR);
    rd(12'h010, vif_pkg::REG_ZERO, vif_pkg::RESP_SLVERR);
    for (int m = 0; m < 6; m++) begin
      wr(vif_pkg::ADDR_CTL, 32'(m) << 4 | 32'h1);
      cmp({27'h0, capture_enable, capture_mode}, 32'(m) | 32'h10);
    end
    rd(vif_pkg::ADDR_CTL, 32'h51);
    // Partial write must touch only its own byte lane
    s_axi_wstrb <= 4'h2;
    wr(vif_pkg::ADDR_CTL, 32'hffffff00);
    s_axi_wstrb <= 4'hf;
    rd(vif_pkg::ADDR_CTL, 32'h0000ff51);
    fin("registers");
    wr(vif_pkg::ADDR_CTL, 32'h1);
    run <= 1'b1;
    stream(400);
    fin("external");
    // Output unit clock reaches its pins before loopback is switched on
    lb <= 1'b1;
    @(posedge aclk);
    wr(vif_pkg::ADDR_CTL, 32'h53);
    stream(400);
    wr(vif_pkg::ADDR_CTL, 32'h1);
    lb <= 1'b0;
    run <= 1'b0;
    fin("loopback");
    repeat (20) @(posedge aclk);
    dv = 8 + int'($urandom % 5);
    wr(vif_pkg::ADDR_CLOCK, 32'(dv) << 8 | 32'h1);
    cmp({31'h0, video_sample_clock_pin_oe}, 32'h1);
    per(dv);
    stream(dv * 30);
    wr(vif_pkg::ADDR_CLOCK, 32'(dv + 2) << 8 | 32'h1);
    @(posedge video_sample_clock_pin_o);
    per(dv + 2);
    fin("internal");
    run <= 1'b1;
    wr(vif_pkg::ADDR_CTL, vif_pkg::CTL_SOFT_RESET_WORD);
    rd(vif_pkg::ADDR_CTL);
    rd(vif_pkg::ADDR_STATUS);
    rd(vif_pkg::ADDR_CLOCK);
    repeat (5) @(posedge own);
    @(posedge aclk);
    // Loopback bit was cleared by the soft reset and is set again
    lb <= 1'b1;
    wr(vif_pkg::ADDR_CTL, 32'h3);
    stream(200);
    wr(vif_pkg::ADDR_CTL, 32'h1);
    lb <= 1'b0;
    fin("soft reset");
    wr(vif_pkg::ADDR_CTL, 32'h0);
    global_power_down <= 1'b1;
    pdm <= 1'b1;
    repeat (2) @(posedge aclk);
    cmp({31'h0, unit_powered_down}, 32'h1);
    stream(200);
    wr(vif_pkg::ADDR_CTL, 32'h5);
    pdm <= 1'b0;
    irq_event <= 1'b1;
    repeat (2) @(posedge aclk);
    cmp({30'h0, unit_powered_down, wake_request}, 32'h1);
    irq_event <= 1'b0;
    stream(200);
    fin("power");
    summarize();
  end
endmodule // tb
